// File: verilog/prb_pkg.sv
// Constants, types and register map of the plain binary read interpreter.
// Summary of operation
// - Read runs plain, no MAC, no encryption.
// - Free read right, or dynamic read right other than Fh, needed, else 6982h.
// - Non plain data file answers 6985h.
// - P1 bit7 set: SFI plus 8-bit offset.
// - P1 bit7 clear: 15-bit offset.
// - SFI 00h reads current file, no reselect.
// - SFI 01h..1Eh selects file, then reads.
// - Le 00h returns rest, at most 256.
// - Le beyond file end returns rest.
// - Success appends status word 9000h.
// - Wrong frame length answers 6700h.
// - Unauthenticated counter overflow answers 6982h.
// - Counter at limit unauthenticated answers 6982h.
// - Authenticated session modes answer 6982h.
// - Chained command ongoing answers 6985h.
// - SFI 00h without selection answers 6985h.
// - Transaction auth file present answers 6985h.
// - Bad P1 or P2 answers 6A86h.
// - Select only with class 00h, A4h.
package prb_pkg;
	// Register byte offsets on the AXI4-Lite slave.
	localparam int          ADDR_W    = 4;
	localparam logic [3:0]  OFF_HDR   = 4'h0;
	localparam logic [3:0]  OFF_LEN   = 4'h4;
	localparam logic [3:0]  OFF_CTRL  = 4'h8;
	localparam logic [3:0]  OFF_STAT  = 4'hC;
	localparam logic [1:0]  RESP_OKAY = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	// Field positions.
	localparam int CTRL_START_BIT = 0;
	localparam int STAT_BUSY_BIT  = 16;
	localparam int STAT_CNT_LSB   = 17;
	// Reset values.
	localparam logic [31:0] HDR_RST = 32'h0000_0000;
	localparam logic [15:0] LEN_RST = 16'h0000;
	localparam logic [15:0] SW_RST  = 16'h0000;
	// Command encodings.
	localparam logic [7:0] CLA_STD    = 8'h00;
	localparam logic [7:0] INS_READ   = 8'hB0;
	localparam logic [7:0] INS_SELECT = 8'hA4;
	localparam logic [7:0] FRAME_LEN_READ = 8'h05;
	localparam logic [3:0] RIGHT_FREE = 4'hE;
	localparam logic [3:0] RIGHT_NONE = 4'hF;
	localparam logic [4:0] SFI_CURRENT = 5'h00;
	localparam logic [4:0] SFI_RFU    = 5'h1F;
	localparam logic [8:0] MAX_RESP   = 9'h100;
	// Status words.
	localparam logic [15:0] SW_OK    = 16'h9000;
	localparam logic [15:0] SW_LEN   = 16'h6700;
	localparam logic [15:0] SW_SEC   = 16'h6982;
	localparam logic [15:0] SW_COND  = 16'h6985;
	localparam logic [15:0] SW_NOFILE = 16'h6A82;
	localparam logic [15:0] SW_P1P2  = 16'h6A86;
	localparam logic [15:0] SW_CLA   = 16'h6E00;
	localparam logic [15:0] SW_INS   = 16'h6D00;
	localparam logic [15:0] SW_MEM   = 16'h6581;

	// Attributes of the targeted file, supplied by the file system.
	typedef struct packed {
		logic        exists;
		logic        plain_data_file;
		logic        app_tx_auth;
		logic [14:0] size;
		logic [3:0]  read_right;
		logic [3:0]  read_write_right;
		logic        dyn_en;
		logic [3:0]  dynamic_file_read_right;
		logic        ctr_ovf;
		logic [23:0] unauth_read_counter;
		logic [23:0] read_counter_limit;
	} prb_file_t;

	// Session state of the tag core.
	typedef struct packed {
		logic session_auth_mode_a;
		logic session_auth_mode_b;
		logic authenticated;
		logic chain_busy;
		logic sel_valid;
	} prb_sess_t;

	// Command frame header as written by software.
	typedef struct packed {
		logic [7:0] cla;
		logic [7:0] ins;
		logic [7:0] p1;
		logic [7:0] p2;
		logic [7:0] le;
		logic [7:0] frame_len;
	} prb_cmd_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_CHECK = 3'b001,
		ST_READ  = 3'b010,
		ST_SEND  = 3'b011,
		ST_SW1   = 3'b100,
		ST_SW2   = 3'b101,
		ST_SELW  = 3'b110
	} prb_state_t;
endpackage

// File: verilog/prb_check.sv
// Header decoder and access checker of the plain binary read command.
`timescale 1ns/1ps
module prb_check
	import prb_pkg::*;
(
	input  prb_cmd_t    cmd,
	input  prb_sess_t   sess,
	input  prb_file_t   finfo,
	output logic [15:0] sw,
	output logic [14:0] offset,
	output logic [4:0]  sfi,
	output logic        sfi_mode
);
	logic free_access;

	// Checks run in a fixed priority; the first failing one names the status.
	always_comb
	begin
		sfi_mode = cmd.p1[7];
		sfi = cmd.p1[4:0];
		// Short form carries an 8-bit offset, long form a 15-bit one.
		offset = sfi_mode ? {7'h00, cmd.p2} : {cmd.p1[6:0], cmd.p2};
		free_access = (finfo.read_right == RIGHT_FREE) ||
			(finfo.read_write_right == RIGHT_FREE) ||
			(finfo.dyn_en && finfo.dynamic_file_read_right != RIGHT_NONE);
		sw = SW_OK;
		if (cmd.cla != CLA_STD)
			sw = SW_CLA;
		else if (sess.chain_busy)
			sw = SW_COND;
		else if (cmd.ins != INS_READ)
			sw = SW_INS;
		else if (cmd.frame_len != FRAME_LEN_READ)
			sw = SW_LEN;
		else if (sfi_mode && (cmd.p1[6:5] != 2'h0 || sfi == SFI_RFU))
			sw = SW_P1P2;
		else if ((!sfi_mode || sfi == SFI_CURRENT) && !sess.sel_valid)
			sw = SW_COND;
		else if (!finfo.exists)
			sw = SW_NOFILE;
		else if (!finfo.plain_data_file)
			sw = SW_COND;
		else if (finfo.app_tx_auth)
			sw = SW_COND;
		else if (sess.session_auth_mode_a || sess.session_auth_mode_b)
			sw = SW_SEC;
		else if (!free_access)
			sw = SW_SEC;
		else if (finfo.dyn_en && finfo.ctr_ovf)
			sw = SW_SEC;
		else if (finfo.dyn_en && !sess.authenticated &&
			finfo.unauth_read_counter >= finfo.read_counter_limit)
			sw = SW_SEC;
		else if (offset >= finfo.size)
			sw = SW_P1P2;
	end
endmodule

// File: verilog/prb_len.sv
// Response length calculator of the plain binary read command.
`timescale 1ns/1ps
module prb_len
	import prb_pkg::*;
(
	input  logic [14:0] size,
	input  logic [14:0] offset,
	input  logic [7:0]  le,
	output logic [8:0]  count
);
	logic [14:0] rem;
	logic [8:0]  cap;

	// Le of zero asks for the rest of the file, clipped to one response.
	always_comb
	begin
		rem = size - offset;
		cap = (le == 8'h00) ? MAX_RESP : {1'b0, le};
		// A request past the end simply returns what is left.
		count = (rem < {6'h00, cap}) ? rem[8:0] : cap;
	end
endmodule

// File: verilog/prb_top.sv
// Plain binary read interpreter with its AXI4-Lite register slave.
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module prb_top
	import prb_pkg::*;
(
	input  logic              aclk,
	input  logic              aresetn,
	input  logic [ADDR_W-1:0] awaddr,
	input  logic              awvalid,
	output logic              awready,
	input  logic [31:0]       wdata,
	input  logic [3:0]        wstrb,
	input  logic              wvalid,
	output logic              wready,
	output logic [1:0]        bresp,
	output logic              bvalid,
	input  logic              bready,
	input  logic [ADDR_W-1:0] araddr,
	input  logic              arvalid,
	output logic              arready,
	output logic [31:0]       rdata,
	output logic [1:0]        rresp,
	output logic              rvalid,
	input  logic              rready,
	input  prb_file_t         finfo,
	input  prb_sess_t         sess,
	output logic [4:0]        lookup_sfi,
	output logic              sel_update,
	output logic              select_req,
	input  logic              select_done,
	input  logic [15:0]       select_sw,
	output logic              mem_req,
	output logic [14:0]       mem_addr,
	input  logic [7:0]        mem_rdata,
	input  logic              mem_ack,
	input  logic              mem_err,
	output logic              resp_valid,
	output logic [7:0]        resp_data,
	output logic              resp_last,
	input  logic              resp_ready
);
	logic              aw_hold_reg, aw_hold_next;
	logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
	logic              w_hold_reg, w_hold_next;
	logic [31:0]       wdata_reg, wdata_next;
	logic [3:0]        wstrb_reg, wstrb_next;
	logic              bvalid_reg, bvalid_next;
	logic [1:0]        bresp_reg, bresp_next;
	logic [31:0]       hdr_reg, hdr_next;
	logic [15:0]       lenf_reg, lenf_next;
	logic              rvalid_reg, rvalid_next;
	logic [31:0]       rdata_reg, rdata_next;
	logic [1:0]        rresp_reg, rresp_next;
	prb_state_t        state_reg, state_next;
	logic [15:0]       sw_reg, sw_next;
	logic [14:0]       addr_reg, addr_next;
	logic [8:0]        cnt_reg, cnt_next;
	logic [8:0]        sent_reg, sent_next;
	logic [7:0]        byte_reg, byte_next;
	logic              go;
	logic              idle;
	prb_cmd_t          cmd;
	logic [15:0]       chk_sw;
	logic [14:0]       offset;
	logic [4:0]        sfi;
	logic              sfi_mode;
	logic [8:0]        count;

	// Merges new write data into a register by byte lane.
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (st[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction

	// The header is a flop copy, so checks see a stable frame.
	assign idle = (state_reg == ST_IDLE);
	// Field order follows the register map: class sits in the low byte.
	assign cmd = {hdr_reg[7:0], hdr_reg[15:8], hdr_reg[23:16],
		hdr_reg[31:24], lenf_reg[7:0], lenf_reg[15:8]};
	assign lookup_sfi = (sfi_mode && sfi != SFI_CURRENT) ? sfi : SFI_CURRENT;

	prb_check u_check (
		.cmd      (cmd),
		.sess     (sess),
		.finfo    (finfo),
		.sw       (chk_sw),
		.offset   (offset),
		.sfi      (sfi),
		.sfi_mode (sfi_mode)
	);

	prb_len u_len (
		.size   (finfo.size),
		.offset (offset),
		.le     (cmd.le),
		.count  (count)
	);

	// Bus handshakes; address and data may arrive in either order.
	assign awready = !aw_hold_reg && !bvalid_reg;
	assign wready  = !w_hold_reg && !bvalid_reg;
	assign bvalid  = bvalid_reg;
	assign bresp   = bresp_reg;
	assign arready = !rvalid_reg;
	assign rvalid  = rvalid_reg;
	assign rdata   = rdata_reg;
	assign rresp   = rresp_reg;

	// Write channel: header writes are ignored while a command runs.
	always_comb
	begin
		aw_hold_next = aw_hold_reg;
		awaddr_next  = awaddr_reg;
		w_hold_next  = w_hold_reg;
		wdata_next   = wdata_reg;
		wstrb_next   = wstrb_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		hdr_next     = hdr_reg;
		lenf_next    = lenf_reg;
		go           = 1'b0;
		if (awvalid && awready)
		begin
			aw_hold_next = 1'b1;
			awaddr_next  = awaddr;
		end
		if (wvalid && wready)
		begin
			w_hold_next = 1'b1;
			wdata_next  = wdata;
			wstrb_next  = wstrb;
		end
		if (bvalid_reg && bready)
			bvalid_next = 1'b0;
		if (aw_hold_reg && w_hold_reg)
		begin
			aw_hold_next = 1'b0;
			w_hold_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = RESP_OKAY;
			case (awaddr_reg)
				OFF_HDR:
					if (idle)
						hdr_next = merge(hdr_reg, wdata_reg, wstrb_reg);
				OFF_LEN:
					if (idle)
						lenf_next = 16'(merge({16'h0000, lenf_reg},
							wdata_reg, wstrb_reg));
				OFF_CTRL:
					go = idle && wstrb_reg[0] && wdata_reg[CTRL_START_BIT];
				OFF_STAT:
					bresp_next = RESP_OKAY;
				default:
					bresp_next = RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_reg <= 1'b0;
			awaddr_reg  <= '0;
			w_hold_reg  <= 1'b0;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
			hdr_reg     <= HDR_RST;
			lenf_reg    <= LEN_RST;
		end
		else
		begin
			aw_hold_reg <= aw_hold_next;
			awaddr_reg  <= awaddr_next;
			w_hold_reg  <= w_hold_next;
			wdata_reg   <= wdata_next;
			wstrb_reg   <= wstrb_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			hdr_reg     <= hdr_next;
			lenf_reg    <= lenf_next;
		end
	end

	// Read channel: one answer per address, unmapped ones get SLVERR.
	always_comb
	begin
		rvalid_next = rvalid_reg;
		rdata_next  = rdata_reg;
		rresp_next  = rresp_reg;
		if (rvalid_reg && rready)
			rvalid_next = 1'b0;
		if (arvalid && arready)
		begin
			rvalid_next = 1'b1;
			rresp_next  = RESP_OKAY;
			case (araddr)
				OFF_HDR:  rdata_next = hdr_reg;
				OFF_LEN:  rdata_next = {16'h0000, lenf_reg};
				OFF_CTRL: rdata_next = 32'h0000_0000;
				OFF_STAT: rdata_next = {6'h00, sent_reg, !idle, sw_reg};
				default:
				begin
					rdata_next = 32'h0000_0000;
					rresp_next = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= RESP_OKAY;
		end
		else
		begin
			rvalid_reg <= rvalid_next;
			rdata_reg  <= rdata_next;
			rresp_reg  <= rresp_next;
		end
	end

	// Command sequencer; data bytes go out exactly as stored, no MAC.
	assign mem_req    = (state_reg == ST_READ);
	assign mem_addr   = addr_reg;
	assign select_req = (state_reg == ST_SELW);
	assign resp_valid = (state_reg == ST_SEND) || (state_reg == ST_SW1) ||
		(state_reg == ST_SW2);
	assign resp_last  = (state_reg == ST_SW2);
	assign resp_data  = byte_reg;
	assign sel_update = (state_reg == ST_CHECK) && (chk_sw == SW_OK) &&
		sfi_mode && (sfi != SFI_CURRENT);

	always_comb
	begin
		state_next = state_reg;
		sw_next    = sw_reg;
		addr_next  = addr_reg;
		cnt_next   = cnt_reg;
		sent_next  = sent_reg;
		byte_next  = byte_reg;
		case (state_reg)
			ST_IDLE:
				if (go)
				begin
					state_next = ST_CHECK;
					sent_next  = 9'h000;
				end
			ST_CHECK:
				if (cmd.cla == CLA_STD && cmd.ins == INS_SELECT &&
					!sess.chain_busy)
					state_next = ST_SELW;
				else if (chk_sw != SW_OK)
				begin
					sw_next    = chk_sw;
					byte_next  = chk_sw[15:8];
					state_next = ST_SW1;
				end
				else
				begin
					sw_next    = SW_OK;
					addr_next  = offset;
					cnt_next   = count;
					state_next = ST_READ;
				end
			ST_SELW:
				if (select_done)
				begin
					sw_next    = select_sw;
					byte_next  = select_sw[15:8];
					state_next = ST_SW1;
				end
			ST_READ:
				if (mem_ack && mem_err)
				begin
					sw_next    = SW_MEM;
					byte_next  = SW_MEM[15:8];
					state_next = ST_SW1;
				end
				else if (mem_ack)
				begin
					byte_next  = mem_rdata;
					state_next = ST_SEND;
				end
			ST_SEND:
				if (resp_ready)
				begin
					addr_next = addr_reg + 15'h0001;
					cnt_next  = cnt_reg - 9'h001;
					sent_next = sent_reg + 9'h001;
					if (cnt_reg == 9'h001)
					begin
						byte_next  = sw_reg[15:8];
						state_next = ST_SW1;
					end
					else
						state_next = ST_READ;
				end
			ST_SW1:
				if (resp_ready)
				begin
					byte_next  = sw_reg[7:0];
					state_next = ST_SW2;
				end
			ST_SW2:
				if (resp_ready)
					state_next = ST_IDLE;
			default:
				state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg <= ST_IDLE;
			sw_reg    <= SW_RST;
			addr_reg  <= 15'h0000;
			cnt_reg   <= 9'h000;
			sent_reg  <= 9'h000;
			byte_reg  <= 8'h00;
		end
		else
		begin
			state_reg <= state_next;
			sw_reg    <= sw_next;
			addr_reg  <= addr_next;
			cnt_reg   <= cnt_next;
			sent_reg  <= sent_next;
			byte_reg  <= byte_next;
		end
	end

	// Checks on the sequencer; all run on the one bus clock.
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_check_fail(logic [15:0] code);
		(state_reg == ST_CHECK) && (chk_sw == code) &&
		!(cmd.cla == CLA_STD && cmd.ins == INS_SELECT);
	endsequence

	sequence s_sw_first(logic [15:0] code);
		(state_reg == ST_SW1) && resp_valid && (resp_data == code[15:8]);
	endsequence

	a_class_reject: assert property (
		(state_reg == ST_CHECK) && (cmd.cla != CLA_STD) |=>
		(sw_reg == SW_CLA) and s_sw_first(SW_CLA))
		else $error("wrong class byte not answered with 6E00h");

	a_length_reject: assert property (
		s_check_fail(SW_LEN) |=> s_sw_first(SW_LEN) ##0 !resp_last)
		else $error("bad frame length not answered with 6700h");

	a_plain_data: assert property (
		(state_reg == ST_READ) && mem_ack && !mem_err |=>
		resp_valid && (resp_data == $past(mem_rdata)) && !resp_last)
		else $error("returned byte differs from memory byte");

	sequence s_last_data;
		(state_reg == ST_SEND) && resp_ready && (cnt_reg == 9'h001);
	endsequence

	a_ok_trailer: assert property (
		s_last_data |=> s_sw_first(SW_OK) ##0 (sw_reg == SW_OK))
		else $error("success not followed by 9000h");

	a_ok_low_byte: assert property (
		(state_reg == ST_SW1) && resp_ready && (sw_reg == SW_OK) |=>
		resp_last && (resp_data == 8'h00))
		else $error("status low byte 00h missing after 90h");

	a_count_bound: assert property (
		(state_reg == ST_CHECK) ##1 (state_reg == ST_READ) |->
		(cnt_reg != 9'h000) && (cnt_reg <= MAX_RESP) &&
		({6'h00, cnt_reg} <= finfo.size - $past(offset)))
		else $error("response length outside file or above 256");

	a_session_refuse: assert property (
		(state_reg == ST_CHECK) && cmd.cla == CLA_STD &&
		cmd.ins == INS_READ && (sess.session_auth_mode_a ||
		sess.session_auth_mode_b) |=> (sw_reg != SW_OK) && !mem_req)
		else $error("read allowed in an authenticated session");

	a_sfi_keep: assert property (
		(state_reg == ST_CHECK) && sfi_mode && (sfi == SFI_CURRENT) |->
		!sel_update)
		else $error("selection changed by short identifier zero");

	a_sfi_select: assert property (
		sel_update |-> (sfi >= 5'h01) && (sfi <= 5'h1E) ##1
		(state_reg == ST_READ) && (mem_addr == {7'h00, cmd.p2}))
		else $error("short identifier select not followed by read");

	a_mem_fault: assert property (
		(state_reg == ST_READ) && mem_ack && mem_err |=>
		s_sw_first(SW_MEM) ##0 (sw_reg == SW_MEM))
		else $error("memory fault not answered with 6581h");

	a_offset_long: assert property (
		(state_reg == ST_CHECK) ##1 (state_reg == ST_READ) && !sfi_mode |->
		mem_addr == {$past(cmd.p1[6:0]), $past(cmd.p2)})
		else $error("long offset not taken from both parameter bytes");
endmodule

// File: verilog/prb_top_fix_note.sv
// Intentionally empty compilation unit.

// File: sim/prb_far_model.sv
// Far-side model of the file memory and the file selection service.
`timescale 1ns/1ps
module prb_far_model
	import prb_pkg::*;
(
	input  logic        aclk,
	input  logic        mem_req,
	input  logic [14:0] mem_addr,
	input  logic        select_req,
	input  logic        slow,
	input  logic [14:0] fail_addr,
	output logic [7:0]  mem_rdata,
	output logic        mem_ack,
	output logic        mem_err,
	output logic        select_done,
	output logic [15:0] select_sw
);
	logic [1:0] dly = 2'h0;

	initial
	begin
		mem_rdata = 8'h00;
		mem_ack = 1'b0;
		mem_err = 1'b0;
		select_done = 1'b0;
		select_sw = 16'h0000;
	end

	// Answers after zero or two wait cycles; idle outputs keep flipping so
	// that a stale value is never mistaken for a fresh one.
	always @(posedge aclk)
	begin
		mem_ack <= 1'b0;
		mem_err <= 1'b0;
		select_done <= 1'b0;
		mem_rdata <= ~mem_rdata;
		select_sw <= ~select_sw;
		if ((mem_req || select_req) && !mem_ack && !select_done)
		begin
			if (dly == (slow ? 2'h2 : 2'h0))
			begin
				dly <= 2'h0;
				mem_ack <= mem_req;
				mem_err <= mem_req && (mem_addr == fail_addr);
				mem_rdata <= mem_addr[7:0] ^ 8'h5A;
				select_done <= select_req;
				select_sw <= SW_OK;
			end
			else
				dly <= dly + 2'h1;
		end
	end
endmodule

// File: sim/tb_top.sv
// Self-checking bench of the plain binary read interpreter.
`timescale 1ns/1ps
module tb_top
	import prb_pkg::*;
();
	logic        aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0, resp_ready = 1'b0;
	logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic        awready, wready, bvalid, arready, rvalid, sel_update;
	logic        select_req, select_done, mem_req, mem_ack, mem_err;
	logic        resp_valid, resp_last;
	logic [1:0]  bresp, rresp;
	logic [4:0]  lookup_sfi, sel_sfi;
	logic [15:0] select_sw;
	logic [14:0] mem_addr, fail_addr = 15'h7FFF;
	logic [7:0]  mem_rdata, resp_data;
	logic [7:0]  got[$];
	prb_file_t   finfo = '0;
	prb_sess_t   sess = '0;
	int          err_count = 0, tests_run = 0, sel_cnt = 0;
	// Baseline command, file and session that lead to a clean read.
	localparam prb_cmd_t C0 = '{CLA_STD, INS_READ, 8'h80, 8'h00, 8'h01,
		FRAME_LEN_READ};
	localparam prb_file_t F0 = '{1'b1, 1'b1, 1'b0, 15'h000A, RIGHT_FREE,
		RIGHT_NONE, 1'b0, RIGHT_NONE, 1'b0, 24'h0, 24'hFFFFFF};
	localparam prb_sess_t S0 = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

	always #25 aclk = ~aclk;

	prb_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .finfo(finfo), .sess(sess),
		.lookup_sfi(lookup_sfi), .sel_update(sel_update),
		.select_req(select_req), .select_done(select_done),
		.select_sw(select_sw), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_err(mem_err),
		.resp_valid(resp_valid), .resp_data(resp_data),
		.resp_last(resp_last), .resp_ready(resp_ready));

	prb_far_model far (.aclk(aclk), .mem_req(mem_req), .mem_addr(mem_addr),
		.select_req(select_req), .slow(slow), .fail_addr(fail_addr),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_err(mem_err),
		.select_done(select_done), .select_sw(select_sw));

	// Selection pulses land while the start write is still answered.
	always @(negedge aclk)
		if (sel_update === 1'b1)
		begin
			sel_cnt++;
			sel_sfi = lookup_sfi;
		end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic tmo(input logic bad);
		if (bad)
		begin
			err_count++;
			$display("[ERR] wait expected done seen timeout");
			end_of_test();
		end
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++)
		begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid === 1'b1)
				break;
		end
		chk("bresp", bresp, RESP_OKAY);
		bready <= 1'b0;
		tmo(n == 100);
	endtask

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++)
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid === 1'b1)
				break;
		end
		d = rdata;
		chk("rresp", rresp, RESP_OKAY);
		rready <= 1'b0;
		tmo(n == 100);
	endtask

	// Sends one command; a stalling reader toggles its ready every cycle.
	task automatic run(input prb_cmd_t c, input prb_file_t f,
		input prb_sess_t s, input logic st, input logic sl);
		logic done;
		done = 1'b0;
		got.delete();
		sel_cnt = 0;
		@(posedge aclk);
		finfo <= f;
		sess <= s;
		slow <= sl;
		axi_wr(OFF_HDR, {c.p2, c.p1, c.ins, c.cla});
		axi_wr(OFF_LEN, {16'h0000, c.frame_len, c.le});
		axi_wr(OFF_CTRL, 32'h0000_0001);
		for (int n = 0; n < 4000 && !done; n++)
		begin
			@(negedge aclk);
			if (resp_valid === 1'b1 && resp_ready)
			begin
				got.push_back(resp_data);
				done = resp_last;
			end
			@(posedge aclk);
			resp_ready <= st ? ~resp_ready : 1'b1;
		end
		tmo(!done);
	endtask

	task automatic judge(input int nb, input int off, input logic [15:0] sw);
		logic [31:0] d;
		chk("resp_len", got.size(), nb + 2);
		if (got.size() == nb + 2)
		begin
			for (int i = 0; i < nb; i++)
				chk("resp_data", got[i], 8'(off + i) ^ 8'h5A);
			chk("resp_sw", {got[nb], got[nb + 1]}, sw);
		end
		axi_rd(OFF_STAT, d);
		chk("stat_sw", d[15:0], sw);
		chk("stat_cnt", d[25:17], nb);
		chk("stat_busy", d[16], 1'b0);
	endtask

	task automatic t_reset();
		logic [31:0] d;
		axi_rd(OFF_STAT, d);
		chk("stat_rst", d, {16'h0000, SW_RST});
		axi_rd(OFF_HDR, d);
		chk("hdr_rst", d, HDR_RST);
		$display("test reset done");
	endtask

	task automatic t_sfi();
		prb_cmd_t c;
		c = C0;
		c.p1 = 8'h82;
		c.p2 = 8'h02;
		c.le = 8'h03;
		run(c, F0, S0, 1'b1, 1'b1);
		chk("sel_pulse", sel_cnt, 1);
		chk("sel_sfi", sel_sfi, 5'h02);
		judge(3, 2, SW_OK);
		$display("test sfi done");
	endtask

	task automatic t_whole();
		prb_cmd_t c;
		prb_file_t f;
		c = C0;
		c.le = 8'h00;
		f = F0;
		f.size = 15'h012C;
		run(c, f, S0, 1'b0, 1'b0);
		chk("sel_pulse", sel_cnt, 0);
		judge(256, 0, SW_OK);
		$display("test whole done");
	endtask

	task automatic t_off15();
		prb_cmd_t c;
		prb_file_t f;
		c = C0;
		c.p1 = 8'h01;
		c.p2 = 8'h02;
		c.le = 8'h10;
		f = F0;
		f.size = 15'h0108;
		f.read_right = RIGHT_NONE;
		f.dyn_en = 1'b1;
		f.dynamic_file_read_right = 4'h0;
		run(c, f, S0, 1'b1, 1'b0);
		judge(6, 'h102, SW_OK);
		$display("test offset done");
	endtask

	task automatic t_fault();
		prb_cmd_t c;
		c = C0;
		c.p2 = 8'h02;
		c.le = 8'h05;
		fail_addr <= 15'h0004;
		run(c, F0, S0, 1'b0, 1'b1);
		judge(2, 2, SW_MEM);
		fail_addr <= 15'h7FFF;
		$display("test fault done");
	endtask

	task automatic t_select();
		prb_cmd_t c;
		c = C0;
		c.ins = INS_SELECT;
		run(c, F0, S0, 1'b0, 1'b1);
		judge(0, 0, SW_OK);
		$display("test select done");
	endtask

	task automatic t_errors();
		prb_cmd_t c;
		prb_file_t f;
		prb_sess_t s;
		logic [15:0] e;
		for (int k = 0; k < 16; k++)
		begin
			c = C0;
			f = F0;
			s = S0;
			e = SW_SEC;
			case (k)
				0: begin c.cla = 8'h01; e = SW_CLA; end
				1: begin s.chain_busy = 1'b1; e = SW_COND; end
				2: begin c.frame_len = 8'h06; e = SW_LEN; end
				3: begin c.p1 = 8'hA1; e = SW_P1P2; end
				4: begin c.p1 = 8'h9F; e = SW_P1P2; end
				5: begin s.sel_valid = 1'b0; e = SW_COND; end
				6: begin f.exists = 1'b0; e = SW_NOFILE; end
				7: begin f.plain_data_file = 1'b0; e = SW_COND; end
				8: begin f.app_tx_auth = 1'b1; e = SW_COND; end
				9: s.session_auth_mode_a = 1'b1;
				10: s.session_auth_mode_b = 1'b1;
				11: f.read_right = 4'h3;
				12: begin f.dyn_en = 1'b1; f.ctr_ovf = 1'b1; end
				13: begin f.dyn_en = 1'b1; f.read_counter_limit = 24'h0; end
				14: begin c.p2 = 8'h0A; e = SW_P1P2; end
				default: begin c.ins = 8'hD6; e = SW_INS; end
			endcase
			run(c, f, s, k[0], 1'b0);
			chk("sel_pulse", sel_cnt, 0);
			judge(0, 0, e);
		end
		$display("test errors done");
	endtask

	initial
	begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_sfi();
		t_whole();
		t_off15();
		t_fault();
		t_select();
		t_errors();
		end_of_test();
	end
endmodule
